// file: rtl/hpb_pkg.sv
// package for the parallel host port
package hpb_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 64;
    localparam logic [5:0] SERIAL_PORT_CONFIG_REG = 6'h30;
    localparam int RESET_MIN_CLKS = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] WAKE_IRQ_BIT = 8'h01;
    localparam int RESET_PULSE_CLKS = 4;

    typedef struct packed {
        logic cs_n;
        logic rw_or_wr_n;
        logic ds_or_rd_n;
        logic ale;
    } hpb_ctrl_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [5:0] addr;
        logic [7:0] wdata;
    } hpb_acc_t;
endpackage

// file: rtl/hpb_port.sv
// parallel host port: mux/non-mux bus, two strobe conventions, irq, reset pin
//
// Contract
// - In multiplexed mode the shared lines first carry the address, then data either way.
// - In non-multiplexed mode the shared lines carry only data.
// - Accesses take place only while chip select is low.
// - In direction-plus-strobe mode direction high is a read and low is a write.
// - In direction-plus-strobe mode the rising edge of the strobe ends the access.
// - In separate-strobe mode the write strobe marks a write and data is taken.
// - In separate-strobe mode the read strobe marks a read and data is driven out.
// - The interrupt output is open drain, pulling low only while an interrupt pends.
// - In multiplexed mode the address is captured while address latch enable is high.
// - Address latch enable selects multiplexed or non-multiplexed form.
// - A high reset pin for at least four clocks forces reset.
// - With terminal functions enabled the device may drive reset out itself.
// - Serial clock, delayed sync and strobe outputs stay idle until the config register is written.
// - A falling edge on the wake input raises an interrupt and optionally a reset pulse.
// - In non-multiplexed mode the address comes on six dedicated pins.
`timescale 1ns/1ps
module hpb_port #(
    parameter int NREGS = hpb_pkg::NUM_REGS
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire hpb_pkg::hpb_ctrl_t ctrl,
    input wire logic strobe_mode_sep,
    input wire logic [7:0] bus_in,
    output logic [7:0] bus_out,
    output logic bus_oe_n,
    input wire logic [5:0] reg_select,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    input wire logic term_func_en,
    input wire logic wake_reset_en,
    input wire logic external_wake_in,
    input wire logic irq_pending_ext,
    output logic irq_out,
    output logic irq_oe_n,
    output logic serial_out_enable,
    output logic [7:0] serial_port_config,
    output logic device_reset
);
    if (NREGS != 2 ** hpb_pkg::ADDR_W) begin : g_nregs_check
        $error("hpb_port supports only 64 registers");
    end

    logic mux_mode;
    logic [5:0] addr_latch;
    logic [5:0] cur_addr;
    logic [7:0] regs [NREGS];
    logic access_on;
    logic access_on_q;
    logic is_read;
    logic end_pulse;
    logic [2:0] rst_cnt;
    logic rst_held;
    logic wake_q;
    logic wake_irq;
    logic [2:0] pulse_cnt;
    logic [7:0] rdata;
    hpb_pkg::hpb_acc_t acc;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mux_mode <= 1'b0;
        end else if (ctrl.ale) begin
            mux_mode <= 1'b1;
        end
    end

    mux_enter_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl.ale |=> mux_mode) else $error("mux mode not entered");
    mux_sticky_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        mux_mode |=> mux_mode) else $error("mux mode dropped");

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            addr_latch <= 6'h00;
        end else if (ctrl.ale) begin
            addr_latch <= bus_in[5:0];
        end
    end

    addr_cap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl.ale |=> addr_latch == $past(bus_in[5:0])) else $error("address not latched");
    addr_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ctrl.ale |=> $stable(addr_latch)) else $error("address changed without ale");

    assign cur_addr = mux_mode ? addr_latch : reg_select;

    always_comb begin
        access_on = 1'b0;
        is_read = 1'b0;
        if (!ctrl.cs_n && !ctrl.ale) begin
            if (strobe_mode_sep) begin
                access_on = !ctrl.rw_or_wr_n || !ctrl.ds_or_rd_n;
                is_read = !ctrl.ds_or_rd_n;
            end else begin
                access_on = !ctrl.ds_or_rd_n;
                is_read = ctrl.rw_or_wr_n;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            access_on_q <= 1'b0;
        end else begin
            access_on_q <= access_on;
        end
    end

    assign end_pulse = access_on_q && !access_on;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acc <= '0;
        end else begin
            acc.we <= access_on && !is_read;
            acc.re <= access_on && is_read;
            acc.addr <= cur_addr;
            if (access_on) acc.wdata <= bus_in;
        end
    end

    cs_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl.cs_n |=> !acc.we && !acc.re) else $error("access without select");
    ale_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl.ale |=> !acc.we && !acc.re) else $error("access during address phase");
    dir_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!ctrl.cs_n && !ctrl.ale && !strobe_mode_sep && !ctrl.ds_or_rd_n
        && !ctrl.rw_or_wr_n) |=> acc.we && !acc.re) else $error("write not decoded");
    dir_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!ctrl.cs_n && !ctrl.ale && !strobe_mode_sep && !ctrl.ds_or_rd_n
        && ctrl.rw_or_wr_n) |=> acc.re && !acc.we) else $error("read not decoded");
    sep_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!ctrl.cs_n && !ctrl.ale && strobe_mode_sep && !ctrl.rw_or_wr_n
        && ctrl.ds_or_rd_n) |=> acc.we && !acc.re) else $error("write strobe lost");
    sep_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!ctrl.cs_n && !ctrl.ale && strobe_mode_sep && !ctrl.ds_or_rd_n)
        |=> acc.re && !acc.we) else $error("read strobe lost");
    data_take_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        access_on |=> acc.wdata == $past(bus_in)) else $error("bus data not taken");

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NREGS; i++) regs[i] <= hpb_pkg::REG_RESET;
        end else if (end_pulse && acc.we) begin
            regs[acc.addr] <= acc.wdata;
        end
    end

    write_commit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (end_pulse && acc.we)
        |=> regs[$past(acc.addr)] == $past(acc.wdata)) else $error("write not committed");
    cfg_stable_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        access_on |=> $stable(serial_port_config)) else $error("write before strobe end");

    assign rdata = regs[cur_addr];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bus_out <= 8'h00;
            bus_oe_n <= 1'b1;
        end else begin
            bus_out <= rdata;
            bus_oe_n <= !(access_on && is_read);
        end
    end

    read_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (access_on && is_read) |=> !bus_oe_n) else $error("read not driven");
    write_nodrive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (access_on && !is_read) |=> bus_oe_n) else $error("bus driven during write");
    desel_nodrive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl.cs_n |=> bus_oe_n) else $error("bus driven while deselected");
    rd_release_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        end_pulse |=> bus_oe_n) else $error("bus held after access end");

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            serial_out_enable <= 1'b0;
        end else if (end_pulse && acc.we && acc.addr == hpb_pkg::SERIAL_PORT_CONFIG_REG) begin
            serial_out_enable <= 1'b1;
        end
    end
    assign serial_port_config = regs[hpb_pkg::SERIAL_PORT_CONFIG_REG];

    serial_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(serial_out_enable) |-> $past(acc.addr) == hpb_pkg::SERIAL_PORT_CONFIG_REG)
        else $error("serial enabled early");
    serial_sticky_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        serial_out_enable |=> serial_out_enable) else $error("serial enable dropped");

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_cnt <= 3'h0;
            rst_held <= 1'b0;
        end else if (!rst_pin_in) begin
            rst_cnt <= 3'h0;
            rst_held <= 1'b0;
        end else if (rst_cnt < 3'(hpb_pkg::RESET_MIN_CLKS - 1)) begin
            rst_cnt <= rst_cnt + 3'h1;
        end else begin
            rst_held <= 1'b1;
        end
    end
    assign device_reset = rst_held;

    reset_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(device_reset) |-> $past(rst_pin_in, 4)) else $error("reset too short");
    reset_drop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !rst_pin_in |=> !device_reset) else $error("reset held without pin");

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wake_q <= 1'b1;
            wake_irq <= 1'b0;
        end else begin
            wake_q <= external_wake_in;
            if (wake_q && !external_wake_in) begin
                wake_irq <= 1'b1;
            end else if (end_pulse && acc.re) begin
                wake_irq <= 1'b0;
            end
        end
    end

    wake_edge_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (wake_q && !external_wake_in) |=> wake_irq) else $error("wake edge lost");
    wake_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (wake_irq && !(end_pulse && acc.re)) |=> wake_irq) else $error("wake irq lost");
    wake_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!wake_irq && !(wake_q && !external_wake_in)) |=> !wake_irq)
        else $error("wake irq without edge");

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pulse_cnt <= 3'h0;
        end else if (term_func_en && wake_reset_en && wake_q && !external_wake_in) begin
            pulse_cnt <= 3'(hpb_pkg::RESET_PULSE_CLKS);
        end else if (pulse_cnt != 3'h0) begin
            pulse_cnt <= pulse_cnt - 3'h1;
        end
    end
    assign rst_pin_out = 1'b1;
    assign rst_pin_oe_n = (pulse_cnt == 3'h0);

    rst_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(!rst_pin_oe_n) |-> !rst_pin_oe_n [*4] ##1 rst_pin_oe_n)
        else $error("reset pulse length");
    wake_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (term_func_en && wake_reset_en && wake_q && !external_wake_in)
        |=> !rst_pin_oe_n) else $error("reset pulse missing");
    no_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!term_func_en && rst_pin_oe_n) |=> rst_pin_oe_n) else $error("reset pulse unasked");

    assign irq_out = 1'b0;
    assign irq_oe_n = !(wake_irq || irq_pending_ext);

    irq_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wake_irq |-> !irq_oe_n && !irq_out) else $error("irq not driven");
endmodule // hpb_port

// file: tb/hpb_cpu.sv
// host processor model driving the parallel port
`timescale 1ns/1ps
module hpb_cpu (
    input wire logic clk,
    input wire logic sep,
    input wire logic [7:0] bus,
    output hpb_pkg::hpb_ctrl_t ctrl,
    output logic [7:0] drv,
    output logic [5:0] sel
);
    initial begin
        ctrl = 4'he;
        drv = 8'h5a;
        sel = 6'h00;
    end
    task automatic acc(input bit mux, input bit rd, input bit cs, input logic [5:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        if (mux) begin
            ctrl.ale <= 1'b1;
            drv <= {2'h0, a};
            @(posedge clk);
        end
        sel <= mux ? ~a : a;
        ctrl.ale <= 1'b0;
        ctrl.cs_n <= ~cs;
        ctrl.rw_or_wr_n <= rd;
        ctrl.ds_or_rd_n <= sep & ~rd;
        drv <= rd ? ~d : d;
        repeat (2) @(posedge clk);
        #1 q = bus;
        @(posedge clk);
        ctrl <= 4'he;
        drv <= ~drv;
        repeat (2) @(posedge clk);
    endtask
endmodule // hpb_cpu

// file: tb/testbench.sv
// self-checking bench for the parallel host port
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module testbench;
    logic sys_clk = 0, resetn = 0, sep = 1, rext = 0, tfe = 0, wre = 0, wake = 1, irqx = 0;
    logic wk = 0, soe_x = 0;
    logic [7:0] bus_in, bus_out, cfg, q, drv;
    logic bus_oe_n, rpo, rpoe_n, rpin, irq_out, irq_oe_n, soe, dres;
    logic [5:0] sel;
    hpb_pkg::hpb_ctrl_t ctrl;
    int n_mismatch = 0, n_tests = 0, cnt;
    logic [7:0] mem [64];
    logic [31:0] seed = 32'h7731c355;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always #10 sys_clk = ~sys_clk;
    assign bus_in = bus_oe_n ? drv : bus_out;
    assign rpin = rpoe_n ? rext : rpo;
    hpb_cpu cpu (.clk(sys_clk), .sep(sep), .bus(bus_in), .ctrl(ctrl), .drv(drv), .sel(sel));
    hpb_port DUT (.sys_clk(sys_clk), .resetn(resetn), .ctrl(ctrl), .strobe_mode_sep(sep),
        .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .reg_select(sel),
        .rst_pin_in(rpin), .rst_pin_out(rpo), .rst_pin_oe_n(rpoe_n), .term_func_en(tfe),
        .wake_reset_en(wre), .external_wake_in(wake), .irq_pending_ext(irqx),
        .irq_out(irq_out), .irq_oe_n(irq_oe_n), .serial_out_enable(soe),
        .serial_port_config(cfg), .device_reset(dres));
    task automatic xfer(input bit mux, input bit rd, input bit cs, input logic [5:0] a);
        logic [7:0] d;
        seed = lfsr(seed);
        d = seed[7:0];
        cpu.acc(mux, rd, cs, a, d, q);
        `CHK(q, (rd && cs) ? mem[a] : (rd ? ~d : d))
        if (cs && !rd) mem[a] = d;
        if (cs && !rd && a == hpb_pkg::SERIAL_PORT_CONFIG_REG) soe_x = 1'b1;
        if (cs && rd) wk = 1'b0;
        `CHK({soe, cfg}, {soe_x, mem[hpb_pkg::SERIAL_PORT_CONFIG_REG]})
        `CHK({bus_oe_n, irq_out, irq_oe_n}, {1'b1, 1'b0, ~(irqx | wk)})
    endtask
    task automatic wrap_up;
        $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic hold_rst(input int n);
        @(posedge sys_clk);
        rext <= 1'b1;
        repeat (n) @(posedge sys_clk);
        rext <= 1'b0;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        for (int i = 0; i < 64; i++) mem[i] = hpb_pkg::REG_RESET;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        `CHK({bus_oe_n, soe, irq_oe_n, rpoe_n}, 4'hb)
        xfer(0, 1, 1, 6'h30);
        xfer(0, 0, 0, 6'h30);
        xfer(0, 0, 1, 6'h30);
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            sep <= seed[9];
            xfer(0, seed[8], i % 5 != 0, seed[5:0]);
        end
        $display("test non-multiplexed done");
        for (int i = 0; i < 30; i++) begin
            seed = lfsr(seed);
            sep <= seed[9];
            xfer(1, seed[8], i % 6 != 0, i < 3 ? 6'h30 : seed[5:0]);
        end
        $display("test multiplexed done");
        irqx <= 1'b1;
        xfer(1, 1, 1, 6'h01);
        irqx <= 1'b0;
        hold_rst(2);
        `CHK(dres, 1'b0)
        $display("test irq and short reset done");
        tfe <= 1'b1;
        wre <= 1'b1;
        @(posedge sys_clk);
        wake <= 1'b0;
        wk = 1'b1;
        cnt = 0;
        repeat (12) begin
            @(posedge sys_clk);
            #1 cnt += (rpoe_n === 1'b0);
        end
        `CHK(cnt, hpb_pkg::RESET_PULSE_CLKS)
        `CHK({rpo, irq_oe_n}, {1'b1, ~(irqx | wk)})
        xfer(1, 1, 1, 6'h02);
        $display("test wake done");
        hold_rst(6);
        `CHK(dres, 1'b1)
        $display("test reset pin done");
        wrap_up();
    end
endmodule // testbench
